// ### design/i2c_slave_control_port_regs.vh
`ifndef I2C_SLAVE_CONTROL_PORT_REGS_VH
`define I2C_SLAVE_CONTROL_PORT_REGS_VH

// Fixed upper five bits of the seven-bit slave address
`define I2C_DEV_ADDR_FIXED 5'h0d
// Direction bit value that requests a read
`define I2C_DIR_READ 1'b1
// Width of the internal location address
`define I2C_LOC_ADDR_W 12
// Zero-padded upper bits of the high subaddress byte
`define I2C_SUBH_PAD_MSB 7
`define I2C_SUBH_PAD_LSB 4
// Bits per byte on the wire; the ninth pulse is the acknowledge
`define I2C_BITS_PER_BYTE 4'h8
// Largest and smallest word length in bytes
`define I2C_WORD_LEN_MAX 3'h5
`define I2C_WORD_LEN_MIN 3'h1
// Cycles to let the boot-source pin settle through the synchroniser
`define I2C_STRAP_SETTLE 2'h3
// Default highest valid location
`define I2C_TOP_LOC 12'hfff

`endif

// ### design/pin_sync.v
`timescale 1ns/1ps
// Two-flop synchroniser for a bundle of asynchronous pins
module pin_sync #(
  parameter WIDTH = 2,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
  input wire ref_clk,
  input wire rst,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  always @(posedge ref_clk) begin
    if (rst) begin
      meta_ff <= INIT;
      sync_ff <= INIT;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule // pin_sync

// ### design/i2c_slave_control_port.v
// Function
// - Acts only as bus slave; never starts a transfer nor drives SCL.
// - Responds to address 01101, high select pin, low select pin.
// - Address byte LSB one means read, zero means write.
// - Start is SDA fall with SCL high; then shift eight bits MSB first.
// - Acknowledge own address on ninth pulse, a read only after a valid subaddress; otherwise release and go idle.
// - Stop is SDA rise with SCL high; it always ends a transfer.
// - Start or stop anywhere aborts the sequence at once.
// - Invalid subaddress gets no acknowledge and the port goes idle.
// - Subaddress advances at each word boundary, length from decoder, until stop.
// - Burst read past top keeps returning the top location until master nack.
// - Burst write past top discards the byte, nacks it, goes idle.
// - Writes acknowledge address, both subaddress bytes and every data byte up to the top location.
// - After read address ack the port drives data; master acks to continue.
// - Write carries subaddress high byte, low byte, then data bytes.
// - Port enabled when boot-source select pin is low at power-up.
// - Subaddress is twelve bits; upper four bits of high byte are zero.
`timescale 1ns/1ps
`include "i2c_slave_control_port_regs.vh"
module i2c_slave_control_port #(
  parameter [11:0] TOP_LOC = `I2C_TOP_LOC
) (
  input wire ref_clk,
  input wire rst,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  input wire addr_select_low_pin,
  input wire addr_select_high_pin,
  input wire boot_source_select_pin,
  output wire port_enabled,
  output wire [11:0] loc_addr,
  output wire [2:0] loc_byte_idx,
  input wire dec_valid,
  input wire [2:0] dec_len,
  output wire wr_strobe,
  output wire [7:0] wr_data,
  input wire [7:0] rd_data,
  output wire rd_strobe,
  output wire busy
);

  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_ADDR = 4'h1;
  localparam [3:0] ST_ACK_ADDR = 4'h2;
  localparam [3:0] ST_SUBH = 4'h3;
  localparam [3:0] ST_ACK_SUBH = 4'h4;
  localparam [3:0] ST_SUBL = 4'h5;
  localparam [3:0] ST_ACK_SUBL = 4'h6;
  localparam [3:0] ST_WDATA = 4'h7;
  localparam [3:0] ST_ACK_WDATA = 4'h8;
  localparam [3:0] ST_RDATA = 4'h9;
  localparam [3:0] ST_MACK = 4'ha;

  wire [4:0] pins_s;
  wire scl_s;
  wire sda_s;
  wire sel_low_s;
  wire sel_high_s;
  wire boot_sel_s;

  pin_sync #(
    .WIDTH(5),
    .INIT(5'h03)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in({boot_source_select_pin, addr_select_high_pin, addr_select_low_pin, sda_in, scl_in}),
    .sync_out(pins_s)
  );

  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign sel_low_s = pins_s[2];
  assign sel_high_s = pins_s[3];
  assign boot_sel_s = pins_s[4];

  reg scl_prev_ff;
  reg sda_prev_ff;
  reg [1:0] strap_cnt_ff;
  reg en_ff;
  reg [3:0] state_ff;
  reg [3:0] nxt_state;
  reg [3:0] bit_cnt_ff;
  reg [3:0] nxt_bit_cnt;
  reg [7:0] rx_ff;
  reg [7:0] nxt_rx;
  reg [7:0] tx_ff;
  reg [7:0] nxt_tx;
  reg [3:0] subh_ff;
  reg [3:0] nxt_subh;
  reg [11:0] addr_ff;
  reg [11:0] nxt_addr;
  reg [2:0] idx_ff;
  reg [2:0] nxt_idx;
  reg sub_ok_ff;
  reg nxt_sub_ok;
  reg past_top_ff;
  reg nxt_past_top;
  reg drive_low_ff;
  reg nxt_drive_low;
  reg drive_data_ff;
  reg nxt_drive_data;
  reg wr_strobe_ff;
  reg nxt_wr_strobe;
  reg [7:0] wr_data_ff;
  reg [7:0] nxt_wr_data;
  reg rd_strobe_ff;
  reg nxt_rd_strobe;

  wire scl_rise = scl_s & ~scl_prev_ff;
  wire scl_fall = ~scl_s & scl_prev_ff;
  wire start_seen = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
  wire stop_seen = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;
  wire [6:0] own_addr = {`I2C_DEV_ADDR_FIXED, sel_high_s, sel_low_s};
  wire [7:0] rx_next = {rx_ff[6:0], sda_s};
  wire byte_done = (bit_cnt_ff == `I2C_BITS_PER_BYTE);
  wire len_ok = (dec_len >= `I2C_WORD_LEN_MIN) && (dec_len <= `I2C_WORD_LEN_MAX);

  // True when the current byte closes the word at the current location
  function word_end;
    input [2:0] idx;
    input [2:0] len;
    begin
      word_end = (idx == (len - 3'h1));
    end
  endfunction

  // Strap is caught after reset once the synchroniser has settled
  always @(posedge ref_clk) begin
    if (rst) begin
      strap_cnt_ff <= 2'h0;
      en_ff <= 1'b0;
    end else if (strap_cnt_ff != `I2C_STRAP_SETTLE) begin
      strap_cnt_ff <= strap_cnt_ff + 2'h1;
      if (strap_cnt_ff == (`I2C_STRAP_SETTLE - 2'h1)) begin
        en_ff <= ~boot_sel_s;
      end
    end
  end

  always @* begin
    nxt_state = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_rx = rx_ff;
    nxt_tx = tx_ff;
    nxt_subh = subh_ff;
    nxt_addr = addr_ff;
    nxt_idx = idx_ff;
    nxt_sub_ok = sub_ok_ff;
    nxt_past_top = past_top_ff;
    nxt_drive_low = drive_low_ff;
    nxt_drive_data = drive_data_ff;
    nxt_wr_strobe = 1'b0;
    nxt_wr_data = wr_data_ff;
    nxt_rd_strobe = 1'b0;
    if (!en_ff) begin
      nxt_state = ST_IDLE;
    end else if (stop_seen) begin
      nxt_state = ST_IDLE;
      nxt_drive_low = 1'b0;
      nxt_drive_data = 1'b0;
      nxt_sub_ok = 1'b0;
    end else if (start_seen) begin
      nxt_state = ST_ADDR;
      nxt_bit_cnt = 4'h0;
      nxt_drive_low = 1'b0;
      nxt_drive_data = 1'b0;
    end else begin
      if (scl_rise && bit_cnt_ff != `I2C_BITS_PER_BYTE) begin
        case (state_ff)
          ST_ADDR, ST_SUBH, ST_SUBL, ST_WDATA: begin
            nxt_rx = rx_next;
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end
          default: begin
          end
        endcase
      end
      case (state_ff)
        ST_IDLE: begin
          nxt_drive_low = 1'b0;
          nxt_drive_data = 1'b0;
        end
        ST_ADDR: begin
          if (scl_fall && byte_done) begin
            nxt_bit_cnt = 4'h0;
            if (rx_ff[7:1] != own_addr) begin
              nxt_state = ST_IDLE;
            end else if (rx_ff[0] == `I2C_DIR_READ && !(sub_ok_ff && dec_valid && len_ok)) begin
              nxt_state = ST_IDLE;
            end else begin
              nxt_state = ST_ACK_ADDR;
              nxt_drive_low = 1'b1;
            end
          end
        end
        ST_ACK_ADDR: begin
          if (scl_fall) begin
            nxt_drive_low = 1'b0;
            if (rx_ff[0] == `I2C_DIR_READ) begin
              nxt_state = ST_RDATA;
              nxt_tx = rd_data;
              nxt_rd_strobe = 1'b1;
              nxt_drive_data = 1'b1;
              nxt_bit_cnt = 4'h1;
            end else begin
              nxt_state = ST_SUBH;
              nxt_sub_ok = 1'b0;
            end
          end
        end
        ST_SUBH: begin
          if (scl_fall && byte_done) begin
            nxt_bit_cnt = 4'h0;
            if (rx_ff[`I2C_SUBH_PAD_MSB:`I2C_SUBH_PAD_LSB] != 4'h0) begin
              nxt_state = ST_IDLE;
            end else begin
              nxt_subh = rx_ff[3:0];
              nxt_state = ST_ACK_SUBH;
              nxt_drive_low = 1'b1;
            end
          end
        end
        ST_ACK_SUBH: begin
          if (scl_fall) begin
            nxt_drive_low = 1'b0;
            nxt_state = ST_SUBL;
          end
        end
        ST_SUBL: begin
          if (scl_rise && bit_cnt_ff == (`I2C_BITS_PER_BYTE - 4'h1)) begin
            nxt_addr = {subh_ff, rx_next};
            nxt_idx = 3'h0;
            nxt_past_top = 1'b0;
          end
          if (scl_fall && byte_done) begin
            nxt_bit_cnt = 4'h0;
            if (!dec_valid || !len_ok) begin
              nxt_state = ST_IDLE;
            end else begin
              nxt_state = ST_ACK_SUBL;
              nxt_drive_low = 1'b1;
              nxt_sub_ok = 1'b1;
            end
          end
        end
        ST_ACK_SUBL: begin
          if (scl_fall) begin
            nxt_drive_low = 1'b0;
            nxt_state = ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (scl_fall && byte_done) begin
            nxt_bit_cnt = 4'h0;
            if (past_top_ff || !dec_valid || !len_ok) begin
              nxt_state = ST_IDLE;
            end else begin
              nxt_wr_strobe = 1'b1;
              nxt_wr_data = rx_ff;
              nxt_state = ST_ACK_WDATA;
              nxt_drive_low = 1'b1;
            end
          end
        end
        ST_ACK_WDATA: begin
          if (scl_fall) begin
            nxt_drive_low = 1'b0;
            nxt_state = ST_WDATA;
            if (word_end(idx_ff, dec_len)) begin
              nxt_idx = 3'h0;
              if (addr_ff == TOP_LOC) begin
                nxt_past_top = 1'b1;
              end else begin
                nxt_addr = addr_ff + 12'h001;
              end
            end else begin
              nxt_idx = idx_ff + 3'h1;
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (byte_done) begin
              nxt_state = ST_MACK;
              nxt_drive_data = 1'b0;
              nxt_bit_cnt = 4'h0;
            end else begin
              nxt_tx = {tx_ff[6:0], 1'b0};
              nxt_bit_cnt = bit_cnt_ff + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              nxt_state = ST_IDLE;
            end else begin
              nxt_bit_cnt = 4'h1;
              if (word_end(idx_ff, dec_len)) begin
                nxt_idx = 3'h0;
                if (addr_ff != TOP_LOC) begin
                  nxt_addr = addr_ff + 12'h001;
                end
              end else begin
                nxt_idx = idx_ff + 3'h1;
              end
            end
          end
          if (scl_fall && bit_cnt_ff == 4'h1) begin
            nxt_state = ST_RDATA;
            nxt_tx = rd_data;
            nxt_rd_strobe = 1'b1;
            nxt_drive_data = 1'b1;
          end
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      rx_ff <= 8'h00;
      tx_ff <= 8'h00;
      subh_ff <= 4'h0;
      addr_ff <= 12'h000;
      idx_ff <= 3'h0;
      sub_ok_ff <= 1'b0;
      past_top_ff <= 1'b0;
      drive_low_ff <= 1'b0;
      drive_data_ff <= 1'b0;
      wr_strobe_ff <= 1'b0;
      wr_data_ff <= 8'h00;
      rd_strobe_ff <= 1'b0;
    end else begin
      scl_prev_ff <= scl_s;
      sda_prev_ff <= sda_s;
      state_ff <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      rx_ff <= nxt_rx;
      tx_ff <= nxt_tx;
      subh_ff <= nxt_subh;
      addr_ff <= nxt_addr;
      idx_ff <= nxt_idx;
      sub_ok_ff <= nxt_sub_ok;
      past_top_ff <= nxt_past_top;
      drive_low_ff <= nxt_drive_low;
      drive_data_ff <= nxt_drive_data;
      wr_strobe_ff <= nxt_wr_strobe;
      wr_data_ff <= nxt_wr_data;
      rd_strobe_ff <= nxt_rd_strobe;
    end
  end

  // Open drain: only ever pulls SDA low, SCL is never driven
  assign sda_out = 1'b0;
  assign sda_oe = drive_low_ff | (drive_data_ff & ~tx_ff[7]);
  assign port_enabled = en_ff;
  assign loc_addr = addr_ff;
  assign loc_byte_idx = idx_ff;
  assign wr_strobe = wr_strobe_ff;
  assign wr_data = wr_data_ff;
  assign rd_strobe = rd_strobe_ff;
  assign busy = (state_ff != ST_IDLE);

endmodule // i2c_slave_control_port

// ### verification/i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model (
  output logic scl,
  output logic sda_low,
  input wire sda
);
  // Idle bus: clock parked high, data left to its pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic clk_bit(input logic b, output logic r);
    #80 sda_low = ~b;
    #30 scl = 1'b1;
    #20 r = sda;
    #30 scl = 1'b0;
  endtask
  // One condition per clock high phase
  task automatic start;
    #80 sda_low = 1'b0;
    #30 scl = 1'b1;
    #80 sda_low = 1'b1;
    #80 scl = 1'b0;
  endtask
  task automatic stop;
    #80 sda_low = 1'b1;
    #30 scl = 1'b1;
    #80 sda_low = 1'b0;
    #80;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
    clk_bit(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(~mack, r);
  endtask
endmodule // i2c_master_model

// ### verification/i2c_slave_control_port_sva.sv
`timescale 1ns/1ps
module i2c_slave_control_port_sva #(
  parameter [11:0] TOP_LOC = 12'hfff
) (
  input wire ref_clk,
  input wire rst,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire port_enabled,
  input wire [11:0] loc_addr,
  input wire [2:0] loc_byte_idx,
  input wire [2:0] dec_len,
  input wire wr_strobe,
  input wire rd_strobe,
  input wire busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_open_drain:
    assert property (sda_oe |-> !sda_out) else $error("sda driven high");
  a_no_false_start:
    assert property ($rose(sda_oe) |-> !scl_in) else $error("sda pulled in scl high");
  a_start_wakes:
    assert property ($fell(sda_in) && scl_in && $past(scl_in) && port_enabled |-> ##[1:6] busy) else $error("start missed");
  a_stop_idles:
    assert property ($rose(sda_in) && scl_in && $past(scl_in) |-> ##[1:8] !busy) else $error("stop missed");
  a_idle_released:
    assert property (!busy && !$past(busy) |-> !sda_oe) else $error("sda held in idle");
  a_strap_off:
    assert property (!port_enabled |-> !busy) else $error("busy while off");
  a_wr_in_range:
    assert property (wr_strobe |-> loc_addr <= TOP_LOC && loc_byte_idx < dec_len) else $error("bad write");
  a_rd_in_range:
    assert property (rd_strobe |-> loc_addr <= TOP_LOC && loc_byte_idx < dec_len) else $error("bad read");
  a_wr_single:
    assert property (wr_strobe |=> !wr_strobe [*8]) else $error("write repeated");
  cover property (wr_strobe);
  cover property (rd_strobe);
  cover property ($rose(sda_oe) && busy);
endmodule // i2c_slave_control_port_sva
bind i2c_slave_control_port i2c_slave_control_port_sva #(.TOP_LOC(TOP_LOC)) sva_inst (
  .ref_clk(ref_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .port_enabled(port_enabled), .loc_addr(loc_addr), .loc_byte_idx(loc_byte_idx), .dec_len(dec_len),
  .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .busy(busy));

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0, rst = 1'b1, lo_pin = 1'b0, hi_pin = 1'b0, boot_pin = 1'b0;
  logic scl, m_low, sda_oe, sda_out, port_enabled, wr_strobe, rd_strobe, busy, ak;
  logic [11:0] loc_addr;
  logic [2:0] loc_byte_idx, a3;
  logic [7:0] wr_data;
  logic [7:0] mem [0:127];
  logic [7:0] rdb [0:7];
  int n_fail = 0, total_checks = 0, n_wr = 0, w0;
  wire sda = ~(m_low | (sda_oe & ~sda_out));
  wire [6:0] mi = {loc_addr[3:0], loc_byte_idx};
  // Stand-in memory map: 16 locations, word length cycling 1..5 bytes
  wire dec_valid = loc_addr <= 12'h00f;
  wire [2:0] dec_len = 3'(loc_addr % 12'h005) + 3'h1;
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (wr_strobe) begin
    mem[mi] <= wr_data;
    n_wr <= n_wr + 1;
  end
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 3 + 1);
  i2c_master_model mst (.scl(scl), .sda_low(m_low), .sda(sda));
  i2c_slave_control_port #(.TOP_LOC(12'h00f)) i2c_slave_control_port_inst (
    .ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_select_low_pin(lo_pin), .addr_select_high_pin(hi_pin), .boot_source_select_pin(boot_pin),
    .port_enabled(port_enabled), .loc_addr(loc_addr), .loc_byte_idx(loc_byte_idx), .dec_valid(dec_valid),
    .dec_len(dec_len), .wr_strobe(wr_strobe), .wr_data(wr_data), .rd_data(mem[mi]), .rd_strobe(rd_strobe),
    .busy(busy));
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Off the clock grid so bus edges never coincide with sampling edges
  task automatic xfer_begin;
    @(negedge ref_clk);
    #3 mst.start();
  endtask
  task automatic idle_chk;
    repeat (6) @(negedge ref_clk);
    chk(busy, 1'b0);
  endtask
  function automatic logic [7:0] adr(input logic rw);
    return {5'h0d, hi_pin, lo_pin, rw};
  endfunction
  task automatic open_sub(input logic [15:0] s);
    xfer_begin();
    mst.wr_byte(adr(1'b0), a3[2]);
    mst.wr_byte(s[15:8], a3[1]);
    mst.wr_byte(s[7:0], a3[0]);
  endtask
  task automatic rd_burst(input logic [15:0] s, input int n);
    open_sub(s);
    chk(a3, 3'h7);
    mst.start();
    mst.wr_byte(adr(1'b1), ak);
    chk(ak, 1'b1);
    for (int i = 0; i < n; i++) mst.rd_byte(i < n - 1, rdb[i]);
    mst.stop();
    idle_chk();
  endtask
  task automatic do_reset(input logic b);
    @(negedge ref_clk);
    boot_pin = b;
    rst = 1'b1;
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    repeat (10) @(negedge ref_clk);
  endtask
  task automatic t_addr;
    for (int p = 0; p < 4; p++) begin
      @(negedge ref_clk);
      {hi_pin, lo_pin} = p[1:0];
      for (int a = 0; a < 4; a++) begin
        xfer_begin();
        mst.wr_byte({5'h0d, a[1:0], 1'b0}, ak);
        chk(ak, a == p);
        mst.stop();
        idle_chk();
      end
    end
  endtask
  task automatic t_write;
    w0 = n_wr;
    open_sub(16'h0003);
    chk(a3, 3'h7);
    for (int i = 0; i < 9; i++) begin
      mst.wr_byte(8'ha0 + i[7:0], ak);
      chk(ak, 1'b1);
    end
    mst.stop();
    idle_chk();
    chk(12'(n_wr - w0), 12'h009);
    for (int i = 0; i < 9; i++) chk(mem[i < 4 ? 24 + i : 28 + i], 8'ha0 + i[7:0]);
  endtask
  task automatic t_read;
    rd_burst(16'h0001, 5);
    for (int i = 0; i < 5; i++) chk(rdb[i], mem[i < 2 ? 8 + i : 14 + i]);
  endtask
  task automatic t_top;
    w0 = n_wr;
    open_sub(16'h000f);
    mst.wr_byte(8'h3c, ak);
    chk(ak, 1'b1);
    mst.wr_byte(8'hc3, ak);
    chk(ak, 1'b0);
    idle_chk();
    mst.stop();
    chk(12'(n_wr - w0), 12'h001);
    chk(mem[120], 8'h3c);
    rd_burst(16'h000f, 3);
    for (int i = 0; i < 3; i++) chk(rdb[i], 8'h3c);
  endtask
  task automatic t_bad;
    open_sub(16'h1000);
    chk(a3[1], 1'b0);
    mst.stop();
    idle_chk();
    open_sub(16'h0020);
    chk(a3, 3'h6);
    idle_chk();
    mst.stop();
    // A read with no valid subaddress set since the last stop is refused
    xfer_begin();
    mst.wr_byte(adr(1'b1), ak);
    chk(ak, 1'b0);
    mst.stop();
    idle_chk();
  endtask
  task automatic t_abort;
    w0 = n_wr;
    open_sub(16'h0003);
    mst.clk_bit(1'b0, ak);
    mst.clk_bit(1'b1, ak);
    mst.clk_bit(1'b0, ak);
    mst.stop();
    idle_chk();
    xfer_begin();
    mst.wr_byte(adr(1'b0), ak);
    mst.clk_bit(1'b0, ak);
    mst.start();
    mst.wr_byte(adr(1'b0), ak);
    chk(ak, 1'b1);
    mst.stop();
    idle_chk();
    chk(12'(n_wr - w0), 12'h000);
  endtask
  task automatic t_strap;
    do_reset(1'b1);
    chk(port_enabled, 1'b0);
    xfer_begin();
    mst.wr_byte(adr(1'b0), ak);
    chk(ak, 1'b0);
    mst.stop();
    do_reset(1'b0);
    chk(port_enabled, 1'b1);
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    do_reset(1'b0);
    t_addr();
    t_write();
    t_read();
    t_top();
    t_bad();
    t_abort();
    t_strap();
    final_report();
  end
  initial begin
    #1000000;
    n_fail++;
    $display("[ERR] %0t timeout", $time);
    final_report();
  end
endmodule // tb
